// File: rtl/mgmt_irq_pkg.sv
// constants for the socket management interrupt and window enable block
package mgmt_irq_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_STATUS_CHG = 8'h04;
  localparam logic [7:0] OFS_IRQ_CFG = 8'h05;
  localparam logic [7:0] OFS_WIN_EN = 8'h06;
  localparam logic [7:0] OFS_SOCK_CTRL = 8'h03;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h40;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int BIT_BVD1 = 0;
  localparam int BIT_BVD2 = 1;
  localparam int BIT_RDY = 2;
  localparam int BIT_CD = 3;
  localparam int SEL_LSB = 4;
  localparam int SEL_MSB = 7;
  localparam int BIT_LEGACY_MODE = 4;
  localparam int BIT_CARD_IO = 5;
  localparam int BIT_WIN_RSVD = 5;
  localparam int MEM_WIN_MSB = 4;
  localparam int IO_WIN_LSB = 6;
  // ----------------------------------------
  // reset values and masks
  // ----------------------------------------
  localparam logic [7:0] RST_IRQ_CFG = 8'h00;
  localparam logic [7:0] RST_WIN_EN = 8'h00;
  localparam logic [7:0] RST_SOCK_CTRL = 8'h00;
  localparam logic [3:0] RST_IRQ_MASK = 4'hF;
  localparam logic [7:0] WIN_EN_WMASK = 8'hDF;
  localparam logic [3:0] SEL_OFF = 4'h0;
endpackage

// File: rtl/socket_mgmt_irq.sv
// socket management interrupt steering and window enable registers
`timescale 1ns/1ps

// Behaviour
// [R01] battery dead/status change with enable raises interrupt
// [R02] battery warning enabled only in memory mode
// [R03] ready change with enable raises interrupt
// [R04] card detect change with enable raises interrupt
// [R05] bits 7-4 select line; zero disables
// [R06] select codes map to lines; reserved listed
// [R07] code 1111 routes to line 15
// [R08] bits 0-4 enable memory windows
// [R09] bits 6-7 enable I/O windows
// [R10] status read clears status change flags
// [R11] ready change reads zero in I/O mode
// [R12] legacy mode bit set suppresses the steered line interrupts; o_irq still follows the mask
// [R13] OR sources; reserved codes act disabled
module socket_mgmt_irq (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_bvd1,
  input wire logic i_bvd2,
  input wire logic i_rdy,
  input wire logic i_cd1_n,
  input wire logic i_cd2_n,
  output logic [7:0] o_rdata,
  output logic [15:0] o_irq_line,
  output logic o_irq,
  output logic [4:0] o_mem_win_en,
  output logic [1:0] o_io_win_en
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] irq_cfg_q;
  logic [7:0] win_en_q;
  logic [7:0] sock_ctrl_q;
  logic [3:0] irq_mask_q;
  logic [3:0] chg_q;
  logic [3:0] chg_d;
  logic [4:0] pins_q;
  logic [7:0] rdata_q;
  logic [15:0] line_q;
  logic irq_q;

  // decode of the line select; reserved codes give no line
  function automatic logic [15:0] line_decode(input logic [3:0] sel);
    logic [15:0] v;
    v = 16'h0000;
    unique case (sel)
      4'h3, 4'h4, 4'h5, 4'h7, 4'h9, 4'hA, 4'hB, 4'hC, 4'hE, 4'hF: v[sel] = 1'b1;
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire io_mode = sock_ctrl_q[mgmt_irq_pkg::BIT_CARD_IO];
  wire wr_cfg = i_wr && (i_addr == mgmt_irq_pkg::OFS_IRQ_CFG);
  wire wr_win = i_wr && (i_addr == mgmt_irq_pkg::OFS_WIN_EN);
  wire wr_ctl = i_wr && (i_addr == mgmt_irq_pkg::OFS_SOCK_CTRL);
  wire wr_msk = i_wr && (i_addr == mgmt_irq_pkg::OFS_IRQ_MASK);
  wire rd_chg = i_rd && (i_addr == mgmt_irq_pkg::OFS_STATUS_CHG);
  wire [4:0] pins_now = {i_cd2_n, i_cd1_n, i_rdy, i_bvd2, i_bvd1};
  wire [4:0] pin_diff = pins_now ^ pins_q;
  wire [3:0] evt;
  // bvd1 falls in memory mode, either edge in I/O mode
  assign evt[mgmt_irq_pkg::BIT_BVD1] = io_mode ? pin_diff[0] : (pin_diff[0] && !i_bvd1);
  assign evt[mgmt_irq_pkg::BIT_BVD2] = !io_mode && pin_diff[1] && !i_bvd2;
  assign evt[mgmt_irq_pkg::BIT_RDY] = !io_mode && pin_diff[2]; // [R11]
  assign evt[mgmt_irq_pkg::BIT_CD] = pin_diff[3] || pin_diff[4];
  // a new event in the read cycle survives the clear
  assign chg_d = (rd_chg ? 4'h0 : chg_q) | evt; // [R10]
  wire [3:0] chg_vis = {chg_q[3], chg_q[2] & ~io_mode, chg_q[1:0]}; // [R11]
  wire [3:0] en = irq_cfg_q[3:0] & {1'b1, 1'b1, ~io_mode, 1'b1}; // [R02]
  wire [3:0] pend = chg_vis & en; // [R01] [R03] [R04]
  wire mgmt_req = (|pend) && !sock_ctrl_q[mgmt_irq_pkg::BIT_LEGACY_MODE]; // [R12] [R13]
  wire [3:0] sel = irq_cfg_q[mgmt_irq_pkg::SEL_MSB:mgmt_irq_pkg::SEL_LSB]; // [R05]
  wire [15:0] line_d = mgmt_req ? line_decode(sel) : 16'h0000; // [R06] [R07] [R13]
  wire irq_d = |(chg_vis & irq_mask_q);

  logic [7:0] rsel;
  always_comb begin
    rsel = 8'h00;
    if (i_addr == mgmt_irq_pkg::OFS_STATUS_CHG) begin
      rsel = {4'h0, chg_vis};
    end else if (i_addr == mgmt_irq_pkg::OFS_IRQ_CFG) begin
      rsel = irq_cfg_q;
    end else if (i_addr == mgmt_irq_pkg::OFS_WIN_EN) begin
      rsel = win_en_q;
    end else if (i_addr == mgmt_irq_pkg::OFS_SOCK_CTRL) begin
      rsel = sock_ctrl_q;
    end else if (i_addr == mgmt_irq_pkg::OFS_IRQ_MASK) begin
      rsel = {4'h0, irq_mask_q};
    end
  end

  // ----------------------------------------
  // storage
  // ----------------------------------------
  // one short block per register, so a write strobe can only touch its own target
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      irq_cfg_q <= mgmt_irq_pkg::RST_IRQ_CFG;
    end else if (wr_cfg) begin
      irq_cfg_q <= i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      win_en_q <= mgmt_irq_pkg::RST_WIN_EN;
    end else if (wr_win) begin
      win_en_q <= i_wdata & mgmt_irq_pkg::WIN_EN_WMASK; // [R08] [R09]
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sock_ctrl_q <= mgmt_irq_pkg::RST_SOCK_CTRL;
    end else if (wr_ctl) begin
      sock_ctrl_q <= i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      irq_mask_q <= mgmt_irq_pkg::RST_IRQ_MASK;
    end else if (wr_msk) begin
      irq_mask_q <= i_wdata[3:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      chg_q <= 4'h0;
      pins_q <= 5'h00;
    end else begin
      chg_q <= chg_d;
      pins_q <= pins_now;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rdata_q <= 8'h00;
      line_q <= 16'h0000;
      irq_q <= 1'b0;
    end else begin
      rdata_q <= i_rd ? rsel : 8'h00;
      line_q <= line_d;
      irq_q <= irq_d && !rd_chg;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // the pin sampler starts at zero, so a high card detect pin may flag once after reset
  assign o_rdata = rdata_q;
  assign o_irq_line = line_q;
  assign o_irq = irq_q;
  assign o_mem_win_en = win_en_q[mgmt_irq_pkg::MEM_WIN_MSB:0]; // [R08]
  assign o_io_win_en = win_en_q[7:mgmt_irq_pkg::IO_WIN_LSB]; // [R09]

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_chg_read;
    rd_chg ##1 !$past(evt[0]);
  endsequence
  AST_BVD1_IRQ: assert property (@(posedge i_clk) disable iff (i_srst) // [R01]
    (chg_q[0] && irq_cfg_q[0] && !sock_ctrl_q[4] && sel == 4'h3) |=> o_irq_line[3])
    else $error("bvd1 change not routed");
  AST_BVD2_IO: assert property (@(posedge i_clk) disable iff (i_srst) // [R02]
    (io_mode && irq_cfg_q[3:0] == 4'h2) |=> (o_irq_line == 16'h0000))
    else $error("battery warning fired in io mode");
  AST_RDY_OFF: assert property (@(posedge i_clk) disable iff (i_srst) // [R03]
    (!irq_cfg_q[2] && chg_vis == 4'h4) |=> (o_irq_line == 16'h0000))
    else $error("ready change raised a line while disabled");
  AST_CD_EVT: assert property (@(posedge i_clk) disable iff (i_srst) // [R04]
    (i_cd1_n != pins_q[3]) |=> chg_q[3])
    else $error("card detect change not flagged");
  AST_SEL_OFF: assert property (@(posedge i_clk) disable iff (i_srst) // [R05]
    (sel == mgmt_irq_pkg::SEL_OFF) |=> (o_irq_line == 16'h0000))
    else $error("line driven while disabled");
  AST_RSVD: assert property (@(posedge i_clk) disable iff (i_srst) // [R06]
    (sel == 4'h6 || sel == 4'hD || sel == 4'h1) |=> (o_irq_line == 16'h0000))
    else $error("reserved code drove a line");
  AST_L15: assert property (@(posedge i_clk) disable iff (i_srst) // [R07]
    (mgmt_req && sel == 4'hF) |=> (o_irq_line == 16'h8000))
    else $error("code 1111 not on line 15");
  AST_WIN: assert property (@(posedge i_clk) disable iff (i_srst) // [R08]
    wr_win |=> (o_mem_win_en == $past(i_wdata[4:0]) && o_io_win_en == $past(i_wdata[7:6])))
    else $error("window enables not written");
  AST_CLR: assert property (@(posedge i_clk) disable iff (i_srst) // [R10]
    s_chg_read |-> !chg_q[0])
    else $error("read did not clear flag");
  AST_RDY_IO: assert property (@(posedge i_clk) disable iff (i_srst) // [R11]
    io_mode |-> !chg_vis[2])
    else $error("ready change visible in io mode");
  AST_LEGACY: assert property (@(posedge i_clk) disable iff (i_srst) // [R12]
    sock_ctrl_q[4] |=> (o_irq_line == 16'h0000))
    else $error("legacy mode did not suppress");

  // ----------------------------------------
  // checks: event capture
  // ----------------------------------------
  sequence s_cd_edge;
    (i_cd1_n != pins_q[3]) || (i_cd2_n != pins_q[4]);
  endsequence
  sequence s_bvd1_fall_mem;
    !io_mode && pins_q[0] && !i_bvd1;
  endsequence
  AST_CD2_EVT: assert property (@(posedge i_clk) disable iff (i_srst) // [R04]
    s_cd_edge |=> chg_q[3])
    else $error("card detect edge not flagged");
  AST_BVD1_FALL: assert property (@(posedge i_clk) disable iff (i_srst) // [R01]
    s_bvd1_fall_mem |=> chg_q[0])
    else $error("battery dead fall not flagged");
  AST_BVD1_IO: assert property (@(posedge i_clk) disable iff (i_srst) // [R01]
    (io_mode && i_bvd1 != pins_q[0]) |=> chg_q[0])
    else $error("status change edge not flagged in io mode");
  AST_BVD2_FALL: assert property (@(posedge i_clk) disable iff (i_srst) // [R02]
    (!io_mode && pins_q[1] && !i_bvd2) |=> chg_q[1])
    else $error("battery warning fall not flagged");
  AST_RDY_EVT: assert property (@(posedge i_clk) disable iff (i_srst) // [R03]
    (!io_mode && i_rdy != pins_q[2]) |=> chg_q[2])
    else $error("ready edge not flagged");
  AST_RDY_IO_EVT: assert property (@(posedge i_clk) disable iff (i_srst) // [R11]
    (io_mode && !chg_q[2]) |=> !chg_q[2])
    else $error("ready change set in io mode");

  // ----------------------------------------
  // checks: steering
  // ----------------------------------------
  AST_BVD1_OFF: assert property (@(posedge i_clk) disable iff (i_srst) // [R01]
    (!irq_cfg_q[0] && chg_vis == 4'h1) |=> (o_irq_line == 16'h0000))
    else $error("battery dead change raised a line while disabled");
  AST_BVD2_IRQ: assert property (@(posedge i_clk) disable iff (i_srst) // [R02]
    (chg_q[1] && irq_cfg_q[1] && !io_mode && !sock_ctrl_q[4] && sel == 4'h9) |=> o_irq_line[9])
    else $error("battery warning change not routed");
  AST_RDY_IRQ: assert property (@(posedge i_clk) disable iff (i_srst) // [R03]
    (chg_q[2] && irq_cfg_q[2] && !io_mode && !sock_ctrl_q[4] && sel == 4'hA) |=> o_irq_line[10])
    else $error("ready change not routed");
  AST_CD_IRQ: assert property (@(posedge i_clk) disable iff (i_srst) // [R04]
    (chg_q[3] && irq_cfg_q[3] && !sock_ctrl_q[4] && sel == 4'hB) |=> o_irq_line[11])
    else $error("card detect change not routed");
  AST_L3: assert property (@(posedge i_clk) disable iff (i_srst) // [R06]
    (mgmt_req && sel == 4'h3) |=> (o_irq_line == 16'h0008))
    else $error("code 0011 not on line 3");
  AST_L12: assert property (@(posedge i_clk) disable iff (i_srst) // [R06]
    (mgmt_req && sel == 4'hC) |=> (o_irq_line == 16'h1000))
    else $error("code 1100 not on line 12");
  AST_L14: assert property (@(posedge i_clk) disable iff (i_srst) // [R06]
    (mgmt_req && sel == 4'hE) |=> (o_irq_line == 16'h4000))
    else $error("code 1110 not on line 14");
  AST_RSVD2: assert property (@(posedge i_clk) disable iff (i_srst) // [R06]
    (sel == 4'h2 || sel == 4'h8) |=> (o_irq_line == 16'h0000))
    else $error("reserved code drove a line");
  AST_NO_REQ: assert property (@(posedge i_clk) disable iff (i_srst) // [R13]
    !mgmt_req |=> (o_irq_line == 16'h0000))
    else $error("line driven with nothing pending");
  AST_ONEHOT: assert property (@(posedge i_clk) disable iff (i_srst) // [R13]
    $onehot0(o_irq_line))
    else $error("more than one line driven");
  AST_LEGACY_REQ: assert property (@(posedge i_clk) disable iff (i_srst) // [R12]
    sock_ctrl_q[4] |-> !mgmt_req)
    else $error("request raised in legacy mode");
  AST_IRQ_MASK: assert property (@(posedge i_clk) disable iff (i_srst) // [R13]
    ((chg_vis & irq_mask_q) == 4'h0) |=> !o_irq)
    else $error("interrupt raised with no unmasked flag");

  // ----------------------------------------
  // checks: registers
  // ----------------------------------------
  AST_WIN_HOLD: assert property (@(posedge i_clk) disable iff (i_srst) // [R08]
    !wr_win |=> ($stable(o_mem_win_en) && $stable(o_io_win_en)))
    else $error("window enables moved without a write");
  AST_IO_WIN: assert property (@(posedge i_clk) disable iff (i_srst) // [R09]
    wr_win |=> (o_io_win_en == $past(i_wdata[7:6])))
    else $error("io window enables not written");
  AST_WIN_RSVD: assert property (@(posedge i_clk) disable iff (i_srst) // [R08]
    !win_en_q[mgmt_irq_pkg::BIT_WIN_RSVD])
    else $error("read-only window bit set");
  AST_CLR_ALL: assert property (@(posedge i_clk) disable iff (i_srst) // [R10]
    rd_chg |=> (chg_q == $past(evt)))
    else $error("status read left stale flags");
  AST_HOLD_FLAG: assert property (@(posedge i_clk) disable iff (i_srst) // [R10]
    !rd_chg |=> ((chg_q & $past(chg_q)) == $past(chg_q)))
    else $error("flag lost without a read");
  AST_IRQ_READ: assert property (@(posedge i_clk) disable iff (i_srst) // [R10]
    rd_chg |=> !o_irq)
    else $error("interrupt held across status read");
  AST_STATUS_RD: assert property (@(posedge i_clk) disable iff (i_srst) // [R10]
    rd_chg |=> (o_rdata == {4'h0, $past(chg_vis)}))
    else $error("status read data wrong");
  AST_RDATA_IDLE: assert property (@(posedge i_clk) disable iff (i_srst) // [R08]
    !i_rd |=> (o_rdata == 8'h00))
    else $error("read data without a read");
endmodule

// File: bench/socket_pins_model.sv
// card socket pin level model
`timescale 1ns/1ps
module socket_pins_model (
  input wire logic i_clk,
  input wire logic [4:0] i_lvl,
  output logic [4:0] o_pins
);
  // levels move just after an edge, as a settled card pin would
  always_ff @(posedge i_clk) begin
    o_pins <= i_lvl;
  end
endmodule

// File: bench/tb_top.sv
// self-checking bench for the socket management interrupt block
`timescale 1ns/1ps
module tb_top;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [4:0] lvl = 5'h00;
  logic [4:0] pins;
  logic [7:0] o_rdata;
  logic [15:0] o_irq_line;
  logic o_irq;
  logic [4:0] o_mem_win_en;
  logic [1:0] o_io_win_en;
  logic rd_d = 1'b0;
  logic [7:0] exp_q[$];
  logic [7:0] v;
  int n_errors = 0;
  int checks_done = 0;
  initial forever #2 i_clk = ~i_clk;
  socket_pins_model socket_pins_model_i (.i_clk(i_clk), .i_lvl(lvl), .o_pins(pins));
  socket_mgmt_irq socket_mgmt_irq_i (.i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_bvd1(pins[0]), .i_bvd2(pins[1]), .i_rdy(pins[2]), .i_cd1_n(pins[3]),
    .i_cd2_n(pins[4]), .o_rdata(o_rdata), .o_irq_line(o_irq_line), .o_irq(o_irq),
    .o_mem_win_en(o_mem_win_en), .o_io_win_en(o_io_win_en));
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // a gap cycle after each strobe keeps one assignment per signal per step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic ev(input int b);
    lvl[b] <= ~lvl[b];
    repeat (5) @(posedge i_clk);
  endtask
  always @(posedge i_clk) begin
    if (rd_d && exp_q.size() > 0) check("rdata", {8'h00, o_rdata}, {8'h00, exp_q.pop_front()});
    rd_d <= i_rd;
  end
  task automatic report_and_stop;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge i_clk);
    n_errors++;
    report_and_stop;
  end
  initial begin
    void'($urandom(32'h0E35));
    repeat (8) @(posedge i_clk);
    i_srst <= 1'b0;
    @(posedge i_clk);
    rd(8'h05, 8'h00);
    rd(8'h06, 8'h00);
    lvl <= 5'h03;
    repeat (4) @(posedge i_clk);
    rd(8'h04, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(8'h05, 8'h90 | (8'h01 << i));
      ev(i);
      check("line", o_irq_line, 16'h0200);
      rd(8'h04, 8'h01 << i);
      repeat (3) @(posedge i_clk);
      check("line", o_irq_line, 16'h0000);
    end
    wr(8'h05, 8'h97);
    ev(3);
    check("line", o_irq_line, 16'h0000);
    rd(8'h04, 8'h08);
    for (int c = 0; c < 16; c++) begin
      wr(8'h05, {c[3:0], 4'h8});
      ev(4);
      check("line", o_irq_line, ((16'hDEB8 >> c) & 16'h0001) ? 16'h0001 << c : 16'h0000);
      check("irq", {15'h0000, o_irq}, 16'h0001);
      rd(8'h04, 8'h08);
    end
    wr(8'h03, 8'h20);
    wr(8'h05, 8'h94);
    ev(2);
    check("line", o_irq_line, 16'h0000);
    rd(8'h04, 8'h00);
    wr(8'h03, 8'h10);
    wr(8'h05, 8'h98);
    ev(3);
    check("line", o_irq_line, 16'h0000);
    rd(8'h04, 8'h08);
    wr(8'h03, 8'h00);
    wr(8'h05, 8'h9B);
    ev(2);
    check("line", o_irq_line, 16'h0000);
    check("irq", {15'h0000, o_irq}, 16'h0001);
    wr(8'h40, 8'h00);
    @(posedge i_clk);
    check("irq", {15'h0000, o_irq}, 16'h0000);
    rd(8'h04, 8'h04);
    wr(8'h40, 8'h0F);
    wr(8'h05, 8'h9E);
    ev(0);
    ev(0);
    check("line", o_irq_line, 16'h0000);
    rd(8'h04, 8'h01);
    for (int k = 0; k < 4; k++) begin
      v = 8'($urandom);
      wr(8'h06, v);
      rd(8'h06, v & 8'hDF);
      check("mem", {11'h000, o_mem_win_en}, {11'h000, v[4:0]});
      check("io", {14'h0000, o_io_win_en}, {14'h0000, v[7:6]});
    end
    rd(8'h20, 8'h00);
    repeat (3) @(posedge i_clk);
    report_and_stop;
  end
endmodule
